// ===== nco_consts.svh
`ifndef NCO_CONSTS_SVH
`define NCO_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define NCO_ADDR_CTRL 4'h0
`define NCO_ADDR_CLK 4'h1
`define NCO_ADDR_ACC_LO 4'h2
`define NCO_ADDR_ACC_HI 4'h3
`define NCO_ADDR_ACC_UP 4'h4
`define NCO_ADDR_INC_LO 4'h5
`define NCO_ADDR_INC_HI 4'h6
`define NCO_ADDR_IRQ_STAT 4'h7
`define NCO_ADDR_IRQ_MASK 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define NCO_CTRL_EN 7
`define NCO_CTRL_OE 6
`define NCO_CTRL_OUT 5
`define NCO_CTRL_PFM 0
`define NCO_CLK_PWS_HI 7
`define NCO_CLK_PWS_LO 5
`define NCO_CLK_CKS_HI 1
`define NCO_CLK_CKS_LO 0
`define NCO_IRQ_OVF 0

// ----------------------------------------
// Clock source codes and reset values
// ----------------------------------------
`define NCO_CKS_FAST_OSC 2'h0
`define NCO_CKS_SYS 2'h1
`define NCO_CKS_CELL 2'h2
`define NCO_CKS_PIN 2'h3
`define NCO_RST_BYTE 8'h00
`define NCO_RST_ACC 20'h00000
`define NCO_RST_INC 16'h0000

`endif

// ===== nco_far_side.sv
`timescale 1ns/10ps

module nco_far_side (
  // Clock
  input wire logic core_clk,
  // Clock sources
  output logic internal_fast_osc,
  output logic logic_cell_one_output,
  output logic external_clock_pin
);
  // ----------------------------------------
  // Source edges
  // ----------------------------------------
  initial begin
    internal_fast_osc = 1'b0;
    logic_cell_one_output = 1'b0;
    external_clock_pin = 1'b0;
  end

  // distinct edge counts
  // Each source gets its own count so a wrong select shows up
  task automatic burst(input int f, input int c, input int p);
    for (int i = 0; i < 3; i++) begin
      internal_fast_osc <= (i < f);
      logic_cell_one_output <= (i < c);
      external_clock_pin <= (i < p);
      repeat (6) @(posedge core_clk);
      internal_fast_osc <= 1'b0;
      logic_cell_one_output <= 1'b0;
      external_clock_pin <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask : burst
endmodule : nco_far_side

// ===== nco_pkg.sv
package nco_pkg;

  typedef enum logic [1:0] {LOAD_IDLE, LOAD_ARMED, LOAD_HALF} load_state_t;

endpackage : nco_pkg

// ===== phase_accumulator_oscillator.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "nco_consts.svh"

module phase_accumulator_oscillator (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock sources, asynchronous
  input wire logic internal_fast_osc,
  input wire logic logic_cell_one_output,
  input wire logic external_clock_pin,
  // Outputs
  output logic accumulator_carry_out,
  output logic osc_out,
  output logic osc_pin_out,
  output logic osc_pin_oe_n,
  output logic irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] clk_ctrl_q;
  logic [19:0] acc_q;
  logic [7:0] increment_low_byte_q;
  logic [7:0] increment_high_byte_q;
  logic [15:0] inc_buf_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_mask_q;
  logic [7:0] rdata_q;
  logic out_q;
  logic carry_q;
  logic [7:0] pulse_cnt_q;
  nco_pkg::load_state_t load_q;

  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic [2:0] rise;
  logic src_edge;
  logic tick;
  logic en;
  logic pfm;
  logic [1:0] cks;
  logic [2:0] pws;
  logic [20:0] sum;
  logic wr;
  logic wr_acc;
  logic wr_inc_lo;
  logic wr_inc_hi;

  assign en = ctrl_q[`NCO_CTRL_EN];
  assign pfm = ctrl_q[`NCO_CTRL_PFM];
  assign cks = clk_ctrl_q[`NCO_CLK_CKS_HI:`NCO_CLK_CKS_LO];
  assign pws = clk_ctrl_q[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO];
  assign wr = reg_wr & clk_en;
  assign wr_inc_lo = wr & (reg_addr == `NCO_ADDR_INC_LO);
  assign wr_inc_hi = wr & (reg_addr == `NCO_ADDR_INC_HI);
  assign wr_acc = wr & ((reg_addr == `NCO_ADDR_ACC_LO) | (reg_addr == `NCO_ADDR_ACC_HI)
                        | (reg_addr == `NCO_ADDR_ACC_UP));

  // ----------------------------------------
  // Clock source synchronisers
  // ----------------------------------------
  // Sources are foreign clocks, so they are sampled and edge detected;
  // each must run below half the core clock rate to be seen reliably.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else if (clk_en) begin
          sync1_q[gi] <= (gi == 0) ? internal_fast_osc :
                         (gi == 1) ? logic_cell_one_output : external_clock_pin;
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi] <= sync2_q[gi];
        end
      end
      assign rise[gi] = sync2_q[gi] & ~prev_q[gi];
    end
  endgenerate

  always_comb begin
    unique case (cks)
      `NCO_CKS_FAST_OSC: src_edge = rise[0];
      `NCO_CKS_SYS: src_edge = 1'b1;
      `NCO_CKS_CELL: src_edge = rise[1];
      `NCO_CKS_PIN: src_edge = rise[2];
    endcase
  end

  assign tick = clk_en & en & src_edge;

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  // full add
  assign sum = {1'b0, acc_q} + {5'h00, inc_buf_q};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_q <= `NCO_RST_ACC;
    end else if (wr_acc) begin
      unique case (reg_addr)
        `NCO_ADDR_ACC_LO: acc_q[7:0] <= reg_wdata;
        `NCO_ADDR_ACC_HI: acc_q[15:8] <= reg_wdata;
        default: acc_q[19:16] <= reg_wdata[3:0];
      endcase
    end else if (tick) begin
      acc_q <= sum[19:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      carry_q <= 1'b0;
    end else if (clk_en) begin
      carry_q <= tick & ~wr_acc & sum[20];
    end
  end

  assign accumulator_carry_out = carry_q;

  // ----------------------------------------
  // Increment registers and buffer
  // ----------------------------------------
  // two bytes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      increment_low_byte_q <= `NCO_RST_BYTE;
      increment_high_byte_q <= `NCO_RST_BYTE;
    end else begin
      if (wr_inc_lo) begin
        increment_low_byte_q <= reg_wdata;
      end
      if (wr_inc_hi) begin
        increment_high_byte_q <= reg_wdata;
      end
    end
  end

  // Rewriting the low byte mid-wait restarts the two-edge count.
  // arm on low write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      load_q <= nco_pkg::LOAD_IDLE;
    end else if (clk_en) begin
      if (wr_inc_lo && en) begin
        load_q <= nco_pkg::LOAD_ARMED;
      end else if (!en) begin
        load_q <= nco_pkg::LOAD_IDLE;
      end else if (tick) begin
        unique case (load_q)
          nco_pkg::LOAD_IDLE: load_q <= nco_pkg::LOAD_IDLE;
          nco_pkg::LOAD_ARMED: load_q <= nco_pkg::LOAD_HALF;
          nco_pkg::LOAD_HALF: load_q <= nco_pkg::LOAD_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      inc_buf_q <= `NCO_RST_INC;
    end else if (clk_en) begin
      if (!en) begin
        if (wr_inc_lo) begin
          inc_buf_q[7:0] <= reg_wdata;
        end
        if (wr_inc_hi) begin
          inc_buf_q[15:8] <= reg_wdata;
        end
      end else if (tick && load_q == nco_pkg::LOAD_HALF && !wr_inc_lo) begin
        inc_buf_q <= {increment_high_byte_q, increment_low_byte_q};
      end
    end
  end

  // ----------------------------------------
  // Output shaping
  // ----------------------------------------
  // A pulse longer than the overflow period is restarted by each overflow, so the output stays high.
  // toggle or stretch
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_q <= 1'b0;
      pulse_cnt_q <= `NCO_RST_BYTE;
    end else if (tick) begin
      if (!wr_acc && sum[20]) begin
        if (pfm) begin
          out_q <= 1'b1;
          pulse_cnt_q <= 8'((9'h001 << pws) - 9'h001);
        end else begin
          out_q <= ~out_q;
        end
      end else if (pfm && out_q) begin
        if (pulse_cnt_q == 8'h00) begin
          out_q <= 1'b0;
        end else begin
          pulse_cnt_q <= pulse_cnt_q - 8'h01;
        end
      end
    end
  end

  assign osc_out = out_q;
  assign osc_pin_out = out_q;
  assign osc_pin_oe_n = ~ctrl_q[`NCO_CTRL_OE];

  // ----------------------------------------
  // Control, interrupts, read port
  // ----------------------------------------
  // reset clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q <= `NCO_RST_BYTE;
      clk_ctrl_q <= `NCO_RST_BYTE;
      irq_mask_q <= `NCO_RST_BYTE;
    end else if (wr) begin
      if (reg_addr == `NCO_ADDR_CTRL) begin
        ctrl_q <= reg_wdata & 8'hc1;
      end
      if (reg_addr == `NCO_ADDR_CLK) begin
        clk_ctrl_q <= reg_wdata & 8'he3;
      end
      if (reg_addr == `NCO_ADDR_IRQ_MASK) begin
        irq_mask_q <= reg_wdata & 8'h01;
      end
    end
  end

  // Set wins over a same-cycle write-one clear.
  // overflow interrupt
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat_q <= `NCO_RST_BYTE;
    end else if (clk_en) begin
      irq_stat_q[`NCO_IRQ_OVF] <= carry_q |
        (irq_stat_q[`NCO_IRQ_OVF] &
         ~(wr && reg_addr == `NCO_ADDR_IRQ_STAT && reg_wdata[`NCO_IRQ_OVF]));
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= `NCO_RST_BYTE;
    end else if (clk_en) begin
      rdata_q <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          `NCO_ADDR_CTRL: rdata_q <= {ctrl_q[7:6], out_q, ctrl_q[4:0]};
          `NCO_ADDR_CLK: rdata_q <= clk_ctrl_q;
          `NCO_ADDR_ACC_LO: rdata_q <= acc_q[7:0];
          `NCO_ADDR_ACC_HI: rdata_q <= acc_q[15:8];
          `NCO_ADDR_ACC_UP: rdata_q <= {4'h0, acc_q[19:16]};
          `NCO_ADDR_INC_LO: rdata_q <= increment_low_byte_q;
          `NCO_ADDR_INC_HI: rdata_q <= increment_high_byte_q;
          `NCO_ADDR_IRQ_STAT: rdata_q <= irq_stat_q;
          `NCO_ADDR_IRQ_MASK: rdata_q <= irq_mask_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  acc_add_a: assert property (
    tick && !wr_acc |=> acc_q == $past(sum[19:0]))
    else $error("accumulator did not add increment");

  acc_hold_a: assert property (
    !tick && !wr_acc && clk_en |=> $stable(acc_q))
    else $error("accumulator moved without input edge");

  carry_flag_a: assert property (
    tick && !wr_acc && sum[20] |=> accumulator_carry_out)
    else $error("carry out missing after overflow");

  irq_raise_a: assert property (
    accumulator_carry_out && clk_en |=> irq_stat_q[0])
    else $error("overflow did not set interrupt status");

  buf_late_a: assert property (
    tick && load_q == nco_pkg::LOAD_HALF && !wr_inc_lo && en
    |=> inc_buf_q == $past({increment_high_byte_q, increment_low_byte_q}))
    else $error("increment buffer not loaded on second edge");

  buf_wait_a: assert property (
    wr_inc_lo && en |=> $stable(inc_buf_q))
    else $error("increment buffer loaded too early");

  buf_now_a: assert property (
    wr_inc_hi && !en |=> inc_buf_q[15:8] == $past(reg_wdata))
    else $error("disabled write did not reach buffer");

  fdc_toggle_a: assert property (
    tick && !wr_acc && sum[20] && !pfm |=> osc_out != $past(osc_out))
    else $error("output did not toggle on overflow");

  pulse_start_a: assert property (
    tick && !wr_acc && sum[20] && pfm
    |=> osc_out && pulse_cnt_q == $past(8'((9'h001 << pws) - 9'h001)))
    else $error("pulse did not start with right width");

endmodule : phase_accumulator_oscillator

// ===== phase_accumulator_oscillator_bench.sv
`timescale 1ns/10ps
`include "nco_consts.svh"

module phase_accumulator_oscillator_bench;
  logic core_clk, rst_n, clk_en, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic fast_osc, cell_out, pin_clk, carry, osc_out, pin_out, oe_n, irq;
  logic [19:0] acc_a, acc_b;
  int bad_count = 0;
  int cmp_count = 0;
  int carry_count = 0;

  phase_accumulator_oscillator uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .internal_fast_osc(fast_osc), .logic_cell_one_output(cell_out),
    .external_clock_pin(pin_clk), .accumulator_carry_out(carry), .osc_out(osc_out),
    .osc_pin_out(pin_out), .osc_pin_oe_n(oe_n), .irq(irq));
  nco_far_side far (.core_clk(core_clk), .internal_fast_osc(fast_osc),
    .logic_cell_one_output(cell_out), .external_clock_pin(pin_clk));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (carry === 1'b1) carry_count <= carry_count + 1;

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(nm, {12'h000, rv}, {12'h000, e});
  endtask : rdc
  task automatic get_acc(output logic [19:0] v);
    logic [7:0] lo, hi, up;
    rd(`NCO_ADDR_ACC_LO, lo);
    rd(`NCO_ADDR_ACC_HI, hi);
    rd(`NCO_ADDR_ACC_UP, up);
    v = {up[3:0], hi, lo};
  endtask : get_acc
  task automatic set_acc(input logic [19:0] v);
    wr(`NCO_ADDR_ACC_UP, {4'h0, v[19:16]});
    wr(`NCO_ADDR_ACC_HI, v[15:8]);
    wr(`NCO_ADDR_ACC_LO, v[7:0]);
  endtask : set_acc
  task automatic reset_check();
    rst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int a = 0; a < 10; a++) rdc("reg", (a == 9) ? 4'hf : a[3:0], 8'h00);
    chk("pin_oe_n", oe_n, 20'h00001);
    $display("test reset done");
  endtask : reset_check
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    $display("watchdog expired");
    close_out();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reset_check();
    // Disabled: buffers follow the registers at once
    wr(`NCO_ADDR_INC_HI, 8'h12);
    wr(`NCO_ADDR_INC_LO, 8'h34);
    rdc("inc_hi", `NCO_ADDR_INC_HI, 8'h12);
    rdc("inc_lo", `NCO_ADDR_INC_LO, 8'h34);
    set_acc(20'habcde);
    get_acc(acc_a);
    chk("acc", acc_a, 20'habcde);
    // System clock source adds on both edges the enable stands: two adds
    for (int s = 0; s < 4; s++) begin
      set_acc(20'h00000);
      wr(`NCO_ADDR_CLK, s[7:0]);
      wr(`NCO_ADDR_CTRL, 8'h80);
      if (s != 1) far.burst(1, 2, 3);
      wr(`NCO_ADDR_CTRL, 8'h00);
      get_acc(acc_a);
      chk("acc_sum", acc_a, 20'h01234 * ((s < 2) ? s + 1 : s));
    end
    $display("test source select done");
    // high byte first, load two ticks later
    set_acc(20'h00000);
    wr(`NCO_ADDR_CLK, 8'h03);
    wr(`NCO_ADDR_CTRL, 8'h80);
    wr(`NCO_ADDR_INC_HI, 8'h00);
    wr(`NCO_ADDR_INC_LO, 8'h10);
    rdc("inc_lo", `NCO_ADDR_INC_LO, 8'h10);
    far.burst(0, 0, 1);
    get_acc(acc_a);
    chk("acc_old_inc", acc_a, 20'h01234);
    far.burst(0, 0, 2);
    get_acc(acc_a);
    far.burst(0, 0, 1);
    get_acc(acc_b);
    chk("acc_new_inc", acc_b - acc_a, 20'h00010);
    $display("test double buffer done");
    // Overflow, interrupt and toggle
    wr(`NCO_ADDR_CTRL, 8'h00);
    wr(`NCO_ADDR_INC_HI, 8'h80);
    wr(`NCO_ADDR_INC_LO, 8'h00);
    wr(`NCO_ADDR_IRQ_MASK, 8'h01);
    set_acc(20'hf8000);
    wr(`NCO_ADDR_CTRL, 8'hc0);
    far.burst(0, 0, 1);
    get_acc(acc_a);
    chk("acc_wrap", acc_a, 20'h00000);
    chk("carry_count", carry_count, 20'h00001);
    chk("irq", irq, 20'h00001);
    rdc("status", `NCO_ADDR_IRQ_STAT, 8'h01);
    rdc("ctrl", `NCO_ADDR_CTRL, 8'he0);
    chk("pin_out", pin_out, 20'h00001);
    chk("pin_oe_n", oe_n, 20'h00000);
    set_acc(20'hf8000);
    far.burst(0, 0, 1);
    chk("osc_out", osc_out, 20'h00000);
    chk("carry_count", carry_count, 20'h00002);
    wr(`NCO_ADDR_IRQ_STAT, 8'h01);
    chk("irq_clear", irq, 20'h00000);
    wr(`NCO_ADDR_IRQ_MASK, 8'h00);
    set_acc(20'hf8000);
    far.burst(0, 0, 1);
    chk("irq_masked", irq, 20'h00000);
    rdc("status", `NCO_ADDR_IRQ_STAT, 8'h01);
    chk("osc_out", osc_out, 20'h00001);
    // Leave the output low so the pulse start below is visible
    set_acc(20'hf8000);
    far.burst(0, 0, 1);
    chk("osc_out", osc_out, 20'h00000);
    $display("test overflow done");
    // Pulse mode, width code 1 gives two ticks
    wr(`NCO_ADDR_CLK, 8'h23);
    wr(`NCO_ADDR_CTRL, 8'h81);
    set_acc(20'hf8000);
    far.burst(0, 0, 1);
    chk("pulse_on", osc_out, 20'h00001);
    far.burst(0, 0, 1);
    chk("pulse_hold", osc_out, 20'h00001);
    far.burst(0, 0, 1);
    chk("pulse_off", osc_out, 20'h00000);
    $display("test pulse done");
    reset_check();
    close_out();
  end
endmodule : phase_accumulator_oscillator_bench
